/* File: hw/dart_pkg.sv */
// Function
// RULE1 - Split bit selects two 8-bit timers
// RULE2 - Run bit gates 16-bit or high byte
// RULE3 - Alt clock code picks div12, comparator, osc/8
// RULE4 - Same code picks capture trigger source
// RULE5 - Per-byte choice between alt and system clock
// RULE6 - Non-system count sources synchronised first
// RULE7 - Reload bytes read/write, reset zero
// RULE8 - Count bytes read/write, reset zero
// RULE9 - Second timer 16-bit or split, bit 3
// RULE10 - Second timer clocks incl. osc/8, comparator 1
// RULE11 - 16-bit wrap reloads, sets high flag
// RULE12 - Interrupt requested on each 16-bit overflow
// RULE13 - Low-byte overflow interrupt when bit 5 set
// RULE14 - Second timer capture measures oscillator/comparator period
// RULE15 - High flag set on wrap, software clears
// RULE16 - Low flag set on every low wrap
// RULE17 - Capture enable bit selects capture mode
// RULE18 - Capture copies count to reload, sets flag
// RULE19 - First timer 16-bit mode reloads likewise
// RULE20 - Each split byte reloads from own byte
package dart_pkg;
   localparam int BYTE_W = 8;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hff;

   localparam logic [7:0] ADDR_T2_CTL = 8'hc8;
   localparam logic [7:0] ADDR_T2_RLD_LO = 8'hca;
   localparam logic [7:0] ADDR_T2_RLD_HI = 8'hcb;
   localparam logic [7:0] ADDR_T2_CNT_LO = 8'hcc;
   localparam logic [7:0] ADDR_T2_CNT_HI = 8'hcd;
   localparam logic [7:0] ADDR_T3_CTL = 8'h91;
   localparam logic [7:0] ADDR_T3_RLD_LO = 8'h92;
   localparam logic [7:0] ADDR_T3_RLD_HI = 8'h93;
   localparam logic [7:0] ADDR_T3_CNT_LO = 8'h94;
   localparam logic [7:0] ADDR_T3_CNT_HI = 8'h95;
   localparam logic [7:0] ADDR_CLK_CHOICE = 8'h8e;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'he6;

   // Control register fields, same layout for both timers
   localparam int CTL_FLAG_HI = 7;
   localparam int CTL_FLAG_LO = 6;
   localparam int CTL_LOW_IRQ_EN = 5;
   localparam int CTL_CAP_EN = 4;
   localparam int CTL_SPLIT = 3;
   localparam int CTL_RUN = 2;
   localparam int CTL_XCLK_HI = 1;
   localparam int CTL_XCLK_LO = 0;

   // Clock choice register fields
   localparam int CKC_T2_LOW_SYS = 4;
   localparam int CKC_T2_HIGH_SYS = 5;
   localparam int CKC_T3_LOW_SYS = 6;
   localparam int CKC_T3_HIGH_SYS = 7;

   // Interrupt enable register fields
   localparam int IE_T2 = 5;
   localparam int IE_T3 = 7;

   localparam logic [1:0] XCLK_DIV12_A = 2'h0;
   localparam logic [1:0] XCLK_CMP = 2'h1;
   localparam logic [1:0] XCLK_DIV12_B = 2'h2;
   localparam logic [1:0] XCLK_OSC8 = 2'h3;

   localparam int PRESCALE_DIV = 12;
   localparam int OSC_DIV = 8;
endpackage

/* File: hw/dart_tmr_if.sv */
interface dart_tmr_if;
   logic split;
   logic run;
   logic capEn;
   logic lowSys;
   logic highSys;
   logic altTick;
   logic capTick;
   logic wrCntLo;
   logic wrCntHi;
   logic wrRldLo;
   logic wrRldHi;
   logic [dart_pkg::BYTE_W-1:0] wrData;
   logic [dart_pkg::BYTE_W-1:0] cntLo;
   logic [dart_pkg::BYTE_W-1:0] cntHi;
   logic [dart_pkg::BYTE_W-1:0] rldLo;
   logic [dart_pkg::BYTE_W-1:0] rldHi;
   logic ovfLo;
   logic ovfHi;

   modport ctl(output split, run, capEn, lowSys, highSys, altTick, capTick,
      wrCntLo, wrCntHi, wrRldLo, wrRldHi, wrData,
      input cntLo, cntHi, rldLo, rldHi, ovfLo, ovfHi);
   modport tmr(input split, run, capEn, lowSys, highSys, altTick, capTick,
      wrCntLo, wrCntHi, wrRldLo, wrRldHi, wrData,
      output cntLo, cntHi, rldLo, rldHi, ovfLo, ovfHi);
endinterface

/* File: hw/dart_timer.sv */
module dart_timer (
   input wire logic sys_clk,
   input wire logic rst,
   dart_tmr_if.tmr t
);
   logic [dart_pkg::BYTE_W-1:0] cntLo_q;
   logic [dart_pkg::BYTE_W-1:0] cntHi_q;
   logic [dart_pkg::BYTE_W-1:0] rldLo_q;
   logic [dart_pkg::BYTE_W-1:0] rldHi_q;
   logic tickLo;
   logic tickHi;
   logic incLo;
   logic incHi;
   logic wrapLo;
   logic wrapHi;
   logic doCap;
   logic lowFromRld;

   assign tickLo = t.lowSys | t.altTick; // RULE5
   assign tickHi = t.highSys | t.altTick; // RULE5
   // Low byte free-runs in split mode
   assign incLo = t.split ? tickLo : (t.run & tickLo); // RULE1 RULE2
   assign incHi = t.split ? (t.run & tickHi) : (incLo && cntLo_q == dart_pkg::BYTE_MAX); // RULE2
   assign wrapLo = incLo && cntLo_q == dart_pkg::BYTE_MAX;
   assign wrapHi = incHi && cntHi_q == dart_pkg::BYTE_MAX;
   assign doCap = t.capEn & t.capTick; // RULE17
   // Capture mode lets the 16-bit count wrap freely so captures stay comparable
   assign lowFromRld = t.split | (wrapHi & ~t.capEn); // RULE19 RULE20

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cntLo_q <= dart_pkg::BYTE_RST; // RULE8
      end else if (t.wrCntLo) begin
         cntLo_q <= t.wrData;
      end else if (wrapLo) begin
         cntLo_q <= lowFromRld ? rldLo_q : dart_pkg::BYTE_RST; // RULE11 RULE20
      end else if (incLo) begin
         cntLo_q <= cntLo_q + 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cntHi_q <= dart_pkg::BYTE_RST; // RULE8
      end else if (t.wrCntHi) begin
         cntHi_q <= t.wrData;
      end else if (wrapHi) begin
         cntHi_q <= (t.split | ~t.capEn) ? rldHi_q : dart_pkg::BYTE_RST; // RULE11 RULE20
      end else if (incHi) begin
         cntHi_q <= cntHi_q + 8'h01;
      end
   end

   // A capture beats a software write to the same reload byte
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rldLo_q <= dart_pkg::BYTE_RST; // RULE7
         rldHi_q <= dart_pkg::BYTE_RST; // RULE7
      end else if (doCap) begin
         rldLo_q <= cntLo_q; // RULE18 RULE14
         rldHi_q <= cntHi_q; // RULE18
      end else begin
         if (t.wrRldLo) begin
            rldLo_q <= t.wrData;
         end
         if (t.wrRldHi) begin
            rldHi_q <= t.wrData;
         end
      end
   end

   assign t.cntLo = cntLo_q;
   assign t.cntHi = cntHi_q;
   assign t.rldLo = rldLo_q;
   assign t.rldHi = rldHi_q;
   assign t.ovfLo = wrapLo; // RULE16
   assign t.ovfHi = wrapHi | doCap; // RULE15 RULE18

   a_full_wrap_reload: assert property ( // RULE11
      @(posedge sys_clk) disable iff (rst)
      (!t.split && !t.capEn && wrapHi && !t.wrCntLo && !t.wrCntHi)
      |=> (cntLo_q == $past(rldLo_q) && cntHi_q == $past(rldHi_q)))
      else $error("16-bit wrap did not reload");
   a_split_low_reload: assert property ( // RULE20
      @(posedge sys_clk) disable iff (rst)
      (t.split && wrapLo && !t.wrCntLo) |=> cntLo_q == $past(rldLo_q))
      else $error("split low byte did not reload");
   a_run_gates_high: assert property ( // RULE2
      @(posedge sys_clk) disable iff (rst)
      (t.split && !t.run && !t.wrCntHi) |=> $stable(cntHi_q))
      else $error("high byte moved while stopped");
   a_low_free_run: assert property ( // RULE1
      @(posedge sys_clk) disable iff (rst)
      (t.split && !t.run && t.lowSys && !t.wrCntLo && cntLo_q != dart_pkg::BYTE_MAX)
      |=> cntLo_q == $past(cntLo_q) + 8'h01)
      else $error("split low byte not free running");
   a_capture_copy: assert property ( // RULE18
      @(posedge sys_clk) disable iff (rst)
      doCap |=> (rldLo_q == $past(cntLo_q) && rldHi_q == $past(cntHi_q)))
      else $error("capture did not copy count");
endmodule

/* File: hw/dart_top.sv */
module dart_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrEn,
   input wire logic [7:0] sfrWrData,
   input wire logic sfrRdEn,
   output logic [7:0] sfrRdData,
   input wire logic comparator0,
   input wire logic comparator1,
   input wire logic rtcOsc,
   input wire logic extOsc,
   output logic t2Irq,
   output logic t3Irq
);
   localparam int NSRC = 4;
   localparam int SRC_CMP0 = 0;
   localparam int SRC_RTC = 1;
   localparam int SRC_CMP1 = 2;
   localparam int SRC_EXT = 3;

   dart_tmr_if t2If();
   dart_tmr_if t3If();

   logic [7:0] sfrRdData_q;
   logic t2Irq_q;
   logic t3Irq_q;
   logic [5:0] t2Ctl_q;
   logic [5:0] t3Ctl_q;
   logic t2FlagHi_q;
   logic t2FlagLo_q;
   logic t3FlagHi_q;
   logic t3FlagLo_q;
   logic [7:0] clkChoice_q;
   logic [7:0] irqEnable_q;
   logic [3:0] preCnt_q;
   logic preTick_q;
   logic [NSRC-1:0] srcIn;
   logic [NSRC-1:0] syncA_q;
   logic [NSRC-1:0] syncB_q;
   logic [NSRC-1:0] syncC_q;
   logic [NSRC-1:0] srcRise;
   logic [2:0] rtcDiv_q;
   logic [2:0] extDiv_q;
   logic rtcTick;
   logic extTick;
   logic wrT2Ctl;
   logic wrT3Ctl;
   logic [7:0] rdMux;

   // Asynchronous sources share one synchroniser structure
   assign srcIn[SRC_CMP0] = comparator0;
   assign srcIn[SRC_RTC] = rtcOsc;
   assign srcIn[SRC_CMP1] = comparator1;
   assign srcIn[SRC_EXT] = extOsc;

   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               syncA_q[gi] <= 1'b0;
               syncB_q[gi] <= 1'b0;
               syncC_q[gi] <= 1'b0;
            end else begin
               syncA_q[gi] <= srcIn[gi]; // RULE6 RULE10
               syncB_q[gi] <= syncA_q[gi];
               syncC_q[gi] <= syncB_q[gi];
            end
         end
         // Edge detect only past the second stage
         assign srcRise[gi] = syncB_q[gi] & ~syncC_q[gi];
      end
   endgenerate

   // Oscillators faster than half of sys_clk alias; the user must keep them slow
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rtcDiv_q <= 3'h0;
      end else if (srcRise[SRC_RTC]) begin
         rtcDiv_q <= rtcDiv_q + 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         extDiv_q <= 3'h0;
      end else if (srcRise[SRC_EXT]) begin
         extDiv_q <= extDiv_q + 3'h1;
      end
   end

   assign rtcTick = srcRise[SRC_RTC] && rtcDiv_q == 3'(dart_pkg::OSC_DIV - 1);
   assign extTick = srcRise[SRC_EXT] && extDiv_q == 3'(dart_pkg::OSC_DIV - 1);

   // System clock divided by 12 as a one-cycle enable
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         preCnt_q <= 4'h0;
         preTick_q <= 1'b0;
      end else if (preCnt_q == 4'(dart_pkg::PRESCALE_DIV - 1)) begin
         preCnt_q <= 4'h0;
         preTick_q <= 1'b1;
      end else begin
         preCnt_q <= preCnt_q + 4'h1;
         preTick_q <= 1'b0;
      end
   end

   // Alternate clock and capture trigger selection
   always_comb begin
      unique case (t2Ctl_q[dart_pkg::CTL_XCLK_HI:dart_pkg::CTL_XCLK_LO]) // RULE3
         dart_pkg::XCLK_DIV12_A: t2If.altTick = preTick_q;
         dart_pkg::XCLK_CMP: t2If.altTick = srcRise[SRC_CMP0];
         dart_pkg::XCLK_DIV12_B: t2If.altTick = preTick_q;
         dart_pkg::XCLK_OSC8: t2If.altTick = rtcTick;
      endcase
   end
   assign t2If.capTick = t2Ctl_q[dart_pkg::CTL_XCLK_HI] ? srcRise[SRC_CMP0] : rtcTick; // RULE4

   // Reserved code 10 falls back to the divide-by-12 tick
   always_comb begin
      unique case (t3Ctl_q[dart_pkg::CTL_XCLK_HI:dart_pkg::CTL_XCLK_LO]) // RULE10
         dart_pkg::XCLK_DIV12_A: t3If.altTick = preTick_q;
         dart_pkg::XCLK_CMP: t3If.altTick = srcRise[SRC_CMP1];
         dart_pkg::XCLK_DIV12_B: t3If.altTick = preTick_q;
         dart_pkg::XCLK_OSC8: t3If.altTick = extTick;
      endcase
   end
   assign t3If.capTick = t3Ctl_q[dart_pkg::CTL_XCLK_HI] ? srcRise[SRC_CMP1] : extTick; // RULE14

   assign t2If.split = t2Ctl_q[dart_pkg::CTL_SPLIT]; // RULE1
   assign t2If.run = t2Ctl_q[dart_pkg::CTL_RUN]; // RULE2
   assign t2If.capEn = t2Ctl_q[dart_pkg::CTL_CAP_EN]; // RULE17
   assign t2If.lowSys = clkChoice_q[dart_pkg::CKC_T2_LOW_SYS]; // RULE5
   assign t2If.highSys = clkChoice_q[dart_pkg::CKC_T2_HIGH_SYS]; // RULE5
   assign t3If.split = t3Ctl_q[dart_pkg::CTL_SPLIT]; // RULE9
   assign t3If.run = t3Ctl_q[dart_pkg::CTL_RUN];
   assign t3If.capEn = t3Ctl_q[dart_pkg::CTL_CAP_EN];
   assign t3If.lowSys = clkChoice_q[dart_pkg::CKC_T3_LOW_SYS];
   assign t3If.highSys = clkChoice_q[dart_pkg::CKC_T3_HIGH_SYS];

   // Register write decode
   assign wrT2Ctl = sfrWrEn && sfrAddr == dart_pkg::ADDR_T2_CTL;
   assign wrT3Ctl = sfrWrEn && sfrAddr == dart_pkg::ADDR_T3_CTL;
   assign t2If.wrData = sfrWrData;
   assign t3If.wrData = sfrWrData;
   assign t2If.wrRldLo = sfrWrEn && sfrAddr == dart_pkg::ADDR_T2_RLD_LO; // RULE7
   assign t2If.wrRldHi = sfrWrEn && sfrAddr == dart_pkg::ADDR_T2_RLD_HI; // RULE7
   assign t2If.wrCntLo = sfrWrEn && sfrAddr == dart_pkg::ADDR_T2_CNT_LO; // RULE8
   assign t2If.wrCntHi = sfrWrEn && sfrAddr == dart_pkg::ADDR_T2_CNT_HI; // RULE8
   assign t3If.wrRldLo = sfrWrEn && sfrAddr == dart_pkg::ADDR_T3_RLD_LO;
   assign t3If.wrRldHi = sfrWrEn && sfrAddr == dart_pkg::ADDR_T3_RLD_HI;
   assign t3If.wrCntLo = sfrWrEn && sfrAddr == dart_pkg::ADDR_T3_CNT_LO;
   assign t3If.wrCntHi = sfrWrEn && sfrAddr == dart_pkg::ADDR_T3_CNT_HI;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         t2Ctl_q <= 6'h00;
         t3Ctl_q <= 6'h00;
      end else begin
         if (wrT2Ctl) begin
            t2Ctl_q <= sfrWrData[dart_pkg::CTL_LOW_IRQ_EN:0];
         end
         if (wrT3Ctl) begin
            t3Ctl_q <= sfrWrData[dart_pkg::CTL_LOW_IRQ_EN:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         clkChoice_q <= dart_pkg::BYTE_RST;
         irqEnable_q <= dart_pkg::BYTE_RST;
      end else if (sfrWrEn && sfrAddr == dart_pkg::ADDR_CLK_CHOICE) begin
         clkChoice_q <= sfrWrData;
      end else if (sfrWrEn && sfrAddr == dart_pkg::ADDR_IRQ_ENABLE) begin
         irqEnable_q <= sfrWrData;
      end
   end

   // Overflow flags: hardware set wins over a software clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         t2FlagHi_q <= 1'b0;
         t2FlagLo_q <= 1'b0;
      end else begin
         t2FlagHi_q <= t2If.ovfHi | (wrT2Ctl ? sfrWrData[dart_pkg::CTL_FLAG_HI] : t2FlagHi_q); // RULE15
         t2FlagLo_q <= t2If.ovfLo | (wrT2Ctl ? sfrWrData[dart_pkg::CTL_FLAG_LO] : t2FlagLo_q); // RULE16
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         t3FlagHi_q <= 1'b0;
         t3FlagLo_q <= 1'b0;
      end else begin
         t3FlagHi_q <= t3If.ovfHi | (wrT3Ctl ? sfrWrData[dart_pkg::CTL_FLAG_HI] : t3FlagHi_q); // RULE15
         t3FlagLo_q <= t3If.ovfLo | (wrT3Ctl ? sfrWrData[dart_pkg::CTL_FLAG_LO] : t3FlagLo_q); // RULE16
      end
   end

   // Level requests held until software clears the flag
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         t2Irq_q <= 1'b0;
         t3Irq_q <= 1'b0;
      end else begin
         t2Irq_q <= irqEnable_q[dart_pkg::IE_T2] & (t2FlagHi_q |
            (t2Ctl_q[dart_pkg::CTL_LOW_IRQ_EN] & t2FlagLo_q)); // RULE12 RULE13
         t3Irq_q <= irqEnable_q[dart_pkg::IE_T3] & (t3FlagHi_q |
            (t3Ctl_q[dart_pkg::CTL_LOW_IRQ_EN] & t3FlagLo_q)); // RULE12 RULE13
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      unique case (sfrAddr)
         dart_pkg::ADDR_T2_CTL: rdMux = {t2FlagHi_q, t2FlagLo_q, t2Ctl_q};
         dart_pkg::ADDR_T2_RLD_LO: rdMux = t2If.rldLo;
         dart_pkg::ADDR_T2_RLD_HI: rdMux = t2If.rldHi;
         dart_pkg::ADDR_T2_CNT_LO: rdMux = t2If.cntLo;
         dart_pkg::ADDR_T2_CNT_HI: rdMux = t2If.cntHi;
         dart_pkg::ADDR_T3_CTL: rdMux = {t3FlagHi_q, t3FlagLo_q, t3Ctl_q};
         dart_pkg::ADDR_T3_RLD_LO: rdMux = t3If.rldLo;
         dart_pkg::ADDR_T3_RLD_HI: rdMux = t3If.rldHi;
         dart_pkg::ADDR_T3_CNT_LO: rdMux = t3If.cntLo;
         dart_pkg::ADDR_T3_CNT_HI: rdMux = t3If.cntHi;
         dart_pkg::ADDR_CLK_CHOICE: rdMux = clkChoice_q;
         dart_pkg::ADDR_IRQ_ENABLE: rdMux = irqEnable_q;
         default: rdMux = dart_pkg::BYTE_RST;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sfrRdData_q <= dart_pkg::BYTE_RST;
      end else if (sfrRdEn) begin
         sfrRdData_q <= rdMux;
      end
   end

   assign sfrRdData = sfrRdData_q;
   assign t2Irq = t2Irq_q;
   assign t3Irq = t3Irq_q;

   dart_timer u_timer2 (
      .sys_clk(sys_clk),
      .rst(rst),
      .t(t2If.tmr)
   );

   dart_timer u_timer3 (
      .sys_clk(sys_clk),
      .rst(rst),
      .t(t3If.tmr)
   );

   a_flag_set_wins: assert property ( // RULE15
      @(posedge sys_clk) disable iff (rst)
      t2If.ovfHi |=> t2FlagHi_q)
      else $error("high overflow flag not set");
   a_flag_sticky: assert property ( // RULE15
      @(posedge sys_clk) disable iff (rst)
      (t3FlagHi_q && !wrT3Ctl) |=> t3FlagHi_q)
      else $error("high flag cleared without a write");
   a_low_flag_set: assert property ( // RULE16
      @(posedge sys_clk) disable iff (rst)
      t3If.ovfLo |=> t3FlagLo_q)
      else $error("low overflow flag not set");
   a_irq_on_overflow: assert property ( // RULE12
      @(posedge sys_clk) disable iff (rst)
      (t2If.ovfHi && irqEnable_q[dart_pkg::IE_T2] && !(sfrWrEn && sfrAddr == dart_pkg::ADDR_IRQ_ENABLE))
      |-> ##2 t2Irq_q)
      else $error("no request after overflow");
   a_low_irq_gate: assert property ( // RULE13
      @(posedge sys_clk) disable iff (rst)
      (!t3FlagHi_q && !t3Ctl_q[dart_pkg::CTL_LOW_IRQ_EN]) |=> !t3Irq_q)
      else $error("low overflow raised request while disabled");
   a_prescale_period: assert property ( // RULE3
      @(posedge sys_clk) disable iff (rst)
      preTick_q |-> ##12 preTick_q)
      else $error("divide-by-12 period wrong");
   a_sync_latency: assert property ( // RULE6
      @(posedge sys_clk) disable iff (rst)
      srcRise[SRC_CMP0] |-> ($past(comparator0, 2) && !$past(comparator0, 3)))
      else $error("comparator edge not delayed by synchroniser");
   a_t3_flag_set: assert property ( // RULE15
      @(posedge sys_clk) disable iff (rst)
      t3If.ovfHi
      |=> t3FlagHi_q)
      else $error("timer3 high overflow flag not set");
   a_t2_low_flag: assert property ( // RULE16
      @(posedge sys_clk) disable iff (rst)
      t2If.ovfLo
      |=> t2FlagLo_q)
      else $error("timer2 low overflow flag not set");
   a_t2_high_sticky: assert property ( // RULE15
      @(posedge sys_clk) disable iff (rst)
      (t2FlagHi_q && !wrT2Ctl)
      |=> t2FlagHi_q)
      else $error("timer2 high flag cleared without a write");
   a_t2_low_sticky: assert property ( // RULE16
      @(posedge sys_clk) disable iff (rst)
      (t2FlagLo_q && !wrT2Ctl)
      |=> t2FlagLo_q)
      else $error("timer2 low flag cleared without a write");
   a_t3_irq_overflow: assert property ( // RULE12
      @(posedge sys_clk) disable iff (rst)
      (t3If.ovfHi && irqEnable_q[dart_pkg::IE_T3] && !(sfrWrEn && sfrAddr == dart_pkg::ADDR_IRQ_ENABLE))
      |-> ##2 t3Irq_q)
      else $error("no timer3 request after overflow");
   a_t2_low_irq: assert property ( // RULE13
      @(posedge sys_clk) disable iff (rst)
      (t2FlagLo_q && t2Ctl_q[dart_pkg::CTL_LOW_IRQ_EN] && irqEnable_q[dart_pkg::IE_T2])
      |=> t2Irq_q)
      else $error("low overflow request missing");
   a_irq_disabled: assert property ( // RULE12
      @(posedge sys_clk) disable iff (rst)
      !irqEnable_q[dart_pkg::IE_T2]
      |=> !t2Irq_q)
      else $error("timer2 request while disabled");
   a_sync_cmp1: assert property ( // RULE10
      @(posedge sys_clk) disable iff (rst)
      srcRise[SRC_CMP1]
      |-> ($past(comparator1, 2) && !$past(comparator1, 3)))
      else $error("comparator 1 edge not delayed by synchroniser");
   a_sync_ext: assert property ( // RULE10
      @(posedge sys_clk) disable iff (rst)
      srcRise[SRC_EXT]
      |-> ($past(extOsc, 2) && !$past(extOsc, 3)))
      else $error("external oscillator edge not delayed by synchroniser");
   a_sync_rtc: assert property ( // RULE6
      @(posedge sys_clk) disable iff (rst)
      srcRise[SRC_RTC]
      |-> ($past(rtcOsc, 2) && !$past(rtcOsc, 3)))
      else $error("rtc oscillator edge not delayed by synchroniser");
   a_t2_cmp_capture: assert property ( // RULE4
      @(posedge sys_clk) disable iff (rst)
      (t2Ctl_q[dart_pkg::CTL_CAP_EN] && t2Ctl_q[dart_pkg::CTL_XCLK_HI] && srcRise[SRC_CMP0])
      |=> t2FlagHi_q)
      else $error("comparator capture did not set flag");
endmodule

/* File: dv/dual_auto_reload_timer_test.sv */
module dual_auto_reload_timer_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfrAddr = 8'h00;
   logic sfrWrEn = 1'b0;
   logic [7:0] sfrWrData = 8'h00;
   logic sfrRdEn = 1'b0;
   logic [7:0] sfrRdData;
   // Comparator 0, rtc osc, comparator 1, ext osc
   logic [3:0] src = 4'h0;
   logic t2Irq;
   logic t3Irq;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   logic [7:0] ctlA [2] = '{8'hc8, 8'h91};
   logic [7:0] rldA [2] = '{8'hca, 8'h92};
   int ckA [2] = '{4, 6};
   int ieA [2] = '{5, 7};

   always #25 sys_clk = ~sys_clk;

   dart_top dart_top_inst (
      .sys_clk(sys_clk),
      .rst(rst),
      .sfrAddr(sfrAddr),
      .sfrWrEn(sfrWrEn),
      .sfrWrData(sfrWrData),
      .sfrRdEn(sfrRdEn),
      .sfrRdData(sfrRdData),
      .comparator0(src[0]),
      .comparator1(src[2]),
      .rtcOsc(src[1]),
      .extOsc(src[3]),
      .t2Irq(t2Irq),
      .t3Irq(t3Irq)
   );

   task automatic summarize();
      $display("Checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Generous ceiling; the full run needs at most about two thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end

   function automatic logic [7:0] cx(logic h, logic l, logic le, logic c, logic s,
      logic r, logic [1:0] x);
      return {h, l, le, c, s, r, x};
   endfunction

   function automatic logic [7:0] rng(logic [7:0] v, logic [7:0] lo, logic [7:0] hi);
      return (v >= lo && v <= hi) ? 8'h01 : 8'h00;
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string m);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfrAddr = a;
      sfrWrData = d;
      sfrWrEn = 1'b1;
      @(negedge sys_clk);
      sfrWrEn = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      sfrAddr = a;
      sfrRdEn = 1'b1;
      @(negedge sys_clk);
      sfrRdEn = 1'b0;
      d = sfrRdData;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
      logic [7:0] d;
      rd(a, d);
      check(d, e, m);
   endtask

   // Counts still move while read, so only a window is known
   task automatic rdr(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi,
      input string m);
      logic [7:0] d;
      rd(a, d);
      check(rng(d, lo, hi), 8'h01, m);
   endtask

   task automatic ckIrq(input int i, input logic v);
      check({7'h00, (i == 1) ? t3Irq : t2Irq}, {7'h00, v}, "irq level");
   endtask

   // Period of 8 cycles keeps inputs below sys_clk/4
   task automatic pulse(input int k, input int n);
      repeat (n) begin
         @(negedge sys_clk);
         src[k] = 1'b1;
         repeat (4) @(negedge sys_clk);
         src[k] = 1'b0;
         repeat (3) @(negedge sys_clk);
      end
      repeat (4) @(negedge sys_clk);
   endtask

   initial begin
      int i;
      int k;
      int n;
      logic [7:0] ct;
      logic [7:0] rb;
      logic [7:0] rl;
      logic [7:0] rh;
      void'($urandom(54132));
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      rdc(8'h00, 8'h00, "unmapped read");
      for (i = 0; i < 2; i++) begin
         ct = ctlA[i];
         rb = rldA[i];
         rdc(ct, 8'h00, "ctl reset");
         for (k = 0; k < 4; k++) rdc(rb + 8'(k), 8'h00, "reset value");
         for (k = 0; k < 4; k++) begin
            rl = 8'($urandom);
            wr(rb + 8'(k), rl);
            rdc(rb + 8'(k), rl, "read back");
         end
         // Full 16-bit wrap with reload
         rh = 8'($urandom);
         wr(8'h8e, 8'(1 << ckA[i]));
         wr(8'he6, 8'(1 << ieA[i]));
         wr(rb, 8'h10);
         wr(rb + 8'h01, rh);
         wr(rb + 8'h02, 8'hfa);
         wr(rb + 8'h03, 8'hff);
         wr(ct, cx(0, 0, 0, 0, 0, 1, 2'h0));
         repeat (12) @(negedge sys_clk);
         rdc(ct, cx(1, 1, 0, 0, 0, 1, 2'h0), "wrap flags");
         rdc(rb + 8'h03, rh, "reload high");
         rdr(rb + 8'h02, 8'h10, 8'h30, "reload low");
         ckIrq(i, 1'b1);
         wr(ct, 8'h04);
         repeat (3) @(negedge sys_clk);
         ckIrq(i, 1'b0);
         rdc(ct, 8'h04, "flags cleared");
         wr(ct, 8'h00);
         // Low wrap only: low interrupt needs its own enable
         wr(rb + 8'h02, 8'hfa);
         wr(rb + 8'h03, 8'h20);
         wr(ct, 8'h04);
         repeat (12) @(negedge sys_clk);
         rdc(ct, cx(0, 1, 0, 0, 0, 1, 2'h0), "low flag");
         ckIrq(i, 1'b0);
         rdc(rb + 8'h03, 8'h21, "carry");
         wr(ct, cx(0, 1, 1, 0, 0, 1, 2'h0));
         repeat (3) @(negedge sys_clk);
         ckIrq(i, 1'b1);
         wr(ct, 8'h00);
         // Split: low runs without run bit
         rl = 8'($urandom) & 8'h7f;
         rh = 8'($urandom) & 8'h7f;
         wr(8'h8e, 8'(3 << ckA[i]));
         wr(rb, rl);
         wr(rb + 8'h01, rh);
         wr(rb + 8'h02, 8'hfc);
         wr(rb + 8'h03, 8'hfc);
         wr(ct, cx(0, 0, 0, 0, 1, 0, 2'h0));
         repeat (12) @(negedge sys_clk);
         rdc(rb + 8'h03, 8'hfc, "high gated");
         rdr(rb + 8'h02, rl, rl + 8'h20, "split low");
         rdc(ct, cx(0, 1, 0, 0, 1, 0, 2'h0), "split low flag");
         wr(ct, cx(0, 0, 0, 0, 1, 1, 2'h0));
         repeat (12) @(negedge sys_clk);
         rdr(rb + 8'h03, rh, rh + 8'h20, "split high");
         rdc(ct, cx(1, 0, 0, 0, 1, 1, 2'h0), "split high flag");
         wr(ct, 8'h00);
         // Every alternate clock code
         wr(8'h8e, 8'h00);
         for (k = 0; k < 4; k++) begin
            n = 3 + $urandom % 5;
            wr(rb + 8'h02, 8'h00);
            wr(rb + 8'h03, 8'h00);
            wr(ct, cx(0, 0, 0, 0, 0, 1, 2'(k)));
            if (k == 1) pulse(2 * i, n);
            else if (k == 3) pulse(2 * i + 1, 8 * n);
            else repeat (12 * n) @(negedge sys_clk);
            wr(ct, 8'h00);
            if (k == 1 || k == 3) rdc(rb + 8'h02, 8'(n), "alt count");
            else rdr(rb + 8'h02, 8'(n - 1), 8'(n + 1), "div12 count");
         end
         // Capture on comparator, then on oscillator
         wr(8'h8e, 8'(1 << ckA[i]));
         wr(rb + 8'h02, 8'h00);
         wr(rb + 8'h03, 8'h00);
         wr(ct, cx(0, 0, 0, 1, 0, 1, 2'h2));
         repeat (20) @(negedge sys_clk);
         pulse(2 * i, 1);
         rdc(ct, cx(1, 0, 0, 1, 0, 1, 2'h2), "capture flag");
         rdr(rb, 8'h14, 8'h30, "captured low");
         rdc(rb + 8'h01, 8'h00, "captured high");
         ckIrq(i, 1'b1);
         wr(ct, cx(0, 0, 0, 1, 0, 1, 2'h0));
         pulse(2 * i, 1);
         rdc(ct, cx(0, 0, 0, 1, 0, 1, 2'h0), "no capture");
         pulse(2 * i + 1, 8);
         rdc(ct, cx(1, 0, 0, 1, 0, 1, 2'h0), "osc capture");
         wr(ct, 8'h00);
      end
      summarize();
   end
endmodule
